//--- logic/lsw_write_port.sv
//Contract
//- Serial traffic is accepted only while chip select is low.
//- Command/data select low marks a command byte, high a data byte.
//- One data bit is captured at each rising serial clock edge while selected.
//- Bits are assembled into 8-bit words before acting on them.
//- First received bit lands in the top bit; host sends MSB first.
//- Data is sampled on the first clock transition after select.
//- Backlight is on while its control input is high.
//- Each pixel is 18 bits: six bits each of red, green, blue.
//- Pixel address steps through rows and columns per scan mode direction.
//- Frame memory holds 345600 bytes of pixel data.
`default_nettype none
`include "lsw_params.svh"

module lsw_write_port
  import lsw_pkg::*;
#(
  parameter int H_PIXELS = `LSW_H_PIXELS,
  parameter int V_PIXELS = `LSW_V_PIXELS
)
(
  input wire logic clock, // 10 MHz system clock
  input wire logic rst_n, // Async reset, active low
  input wire logic chip_select_n, // Serial select pin
  input wire logic command_data_select, // Low command, high data
  input wire logic serial_clock, // Serial clock pin
  input wire logic serial_data, // Serial data pin
  input wire logic backlight_enable, // Backlight control pin
  input wire lsw_scan_s scan_mode, // Scan direction, same domain
  output logic word_valid, // Pulse: word complete
  output logic [7:0] word, // Last received word
  output logic word_is_cmd, // Word was a command
  output logic frame_memory_we, // Pulse: pixel write
  output logic [`LSW_ADDR_W-1:0] frame_memory_addr, // Pixel index
  output lsw_pixel_s frame_memory_pixel, // Pixel colour
  output logic backlight_on // Backlight drive
);

  // ****************************************************************
  // Elaboration checks
  // ****************************************************************
  initial
  begin
    if (H_PIXELS > (1 << `LSW_COORD_W) || V_PIXELS > (1 << `LSW_COORD_W))
      $error("lsw_write_port: geometry exceeds coordinate width");
    if ((H_PIXELS * V_PIXELS * `LSW_PIXEL_BITS) / 8 != `LSW_FRAME_BYTES)
      $error("lsw_write_port: geometry does not match frame memory size");
  end

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic cs_n_s;
  logic cmd_data_level;
  logic sclk_s;
  logic sdi_s;
  logic bl_s;

  // All pins share one path so data and clock stay aligned
  lsw_sync #(.W(5)) u_sync (
    .clock(clock),
    .rst_n(rst_n),
    .d({chip_select_n, command_data_select, serial_clock, serial_data, backlight_enable}),
    .q({cs_n_s, cmd_data_level, sclk_s, sdi_s, bl_s})
  );

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // One step toward the far end; wrap flag when the end is passed
  function automatic logic [`LSW_COORD_W:0] step_coord(input lsw_coord_t pos, input lsw_coord_t lo,
                                                        input lsw_coord_t hi, input logic dec);
    logic [`LSW_COORD_W:0] res;
    res = '0;
    if (dec)
      res = (pos == lo) ? {1'b1, hi} : {1'b0, pos - lsw_coord_t'(1)};
    else
      res = (pos == hi) ? {1'b1, lo} : {1'b0, pos + lsw_coord_t'(1)};
    return res;
  endfunction : step_coord

  function automatic logic [`LSW_ADDR_W-1:0] pixel_index(input lsw_coord_t c, input lsw_coord_t r);
    return `LSW_ADDR_W'(int'(r) * H_PIXELS + int'(c));
  endfunction : pixel_index

  // ****************************************************************
  // Receiver and pixel writer
  // ****************************************************************
  lsw_state_s state_r;
  lsw_state_s state_nxt;
  logic sclk_rise;
  logic [7:0] rx_byte;

  // Idle-low clock makes the first transition a rising edge
  assign sclk_rise = sclk_s & ~state_r.sclk_prev;
  assign rx_byte = {state_r.shift[6:0], sdi_s};

  always_comb
  begin
    logic [`LSW_COORD_W:0] cstep;
    logic [`LSW_COORD_W:0] rstep;
    cstep = step_coord(state_r.col, state_r.col_start, state_r.col_end, scan_mode.col_dec);
    rstep = step_coord(state_r.row, state_r.row_start, state_r.row_end, scan_mode.row_dec);
    state_nxt = state_r;
    state_nxt.sclk_prev = sclk_s;
    state_nxt.word_valid = 1'b0;
    state_nxt.fm_we = 1'b0;
    state_nxt.backlight = bl_s;
    if (cs_n_s)
    begin
      // Deselect aborts a partial word
      state_nxt.bit_cnt = `LSW_BIT_CNT_RST;
    end
    else if (sclk_rise)
    begin
      state_nxt.shift = rx_byte;
      state_nxt.bit_cnt = state_r.bit_cnt + 3'h1;
      if (state_r.bit_cnt == `LSW_LAST_BIT)
      begin
        state_nxt.word = rx_byte;
        state_nxt.word_valid = 1'b1;
        state_nxt.word_is_cmd = ~cmd_data_level;
        if (!cmd_data_level)
        begin
          state_nxt.arg_idx = 2'h0;
          unique case (rx_byte)
            `LSW_CMD_COL_SET: state_nxt.mode = MODE_COL;
            `LSW_CMD_ROW_SET: state_nxt.mode = MODE_ROW;
            `LSW_CMD_MEM_WRITE:
            begin
              // Writing starts at the window corner already set
              state_nxt.mode = MODE_WRITE;
              state_nxt.col = scan_mode.col_dec ? state_r.col_end : state_r.col_start;
              state_nxt.row = scan_mode.row_dec ? state_r.row_end : state_r.row_start;
            end
            default: state_nxt.mode = MODE_IDLE;
          endcase
        end
        else
        begin
          unique case (state_r.mode)
            MODE_IDLE:
            begin
              state_nxt.arg_idx = state_r.arg_idx;
            end
            MODE_COL, MODE_ROW:
            begin
              // Big-endian start then end; extra bytes are ignored
              state_nxt.arg_idx = state_r.arg_idx + 2'h1;
              state_nxt.arg_hi = rx_byte;
              if (state_r.arg_idx[0])
              begin
                if (state_r.mode == MODE_COL && !state_r.arg_idx[1])
                  state_nxt.col_start = lsw_coord_t'({state_r.arg_hi, rx_byte});
                if (state_r.mode == MODE_COL && state_r.arg_idx[1])
                  state_nxt.col_end = lsw_coord_t'({state_r.arg_hi, rx_byte});
                if (state_r.mode == MODE_ROW && !state_r.arg_idx[1])
                  state_nxt.row_start = lsw_coord_t'({state_r.arg_hi, rx_byte});
                if (state_r.mode == MODE_ROW && state_r.arg_idx[1])
                  state_nxt.row_end = lsw_coord_t'({state_r.arg_hi, rx_byte});
              end
              if (state_r.arg_idx == `LSW_ARG_LAST)
                state_nxt.mode = MODE_IDLE;
            end
            MODE_WRITE:
            begin
              // Colour in the top six bits of each of three bytes
              state_nxt.arg_idx = state_r.arg_idx + 2'h1;
              if (state_r.arg_idx == 2'h0)
                state_nxt.red = rx_byte[7:2];
              if (state_r.arg_idx == 2'h1)
                state_nxt.green = rx_byte[7:2];
              if (state_r.arg_idx == `LSW_PIX_LAST)
              begin
                state_nxt.arg_idx = 2'h0;
                state_nxt.fm_we = 1'b1;
                state_nxt.fm_addr = pixel_index(state_r.col, state_r.row);
                state_nxt.fm_pixel = '{red: state_r.red, green: state_r.green, blue: rx_byte[7:2]};
                // Fast axis steps each pixel, slow axis on wrap
                if (scan_mode.row_first)
                begin
                  state_nxt.row = rstep[`LSW_COORD_W-1:0];
                  if (rstep[`LSW_COORD_W])
                    state_nxt.col = cstep[`LSW_COORD_W-1:0];
                end
                else
                begin
                  state_nxt.col = cstep[`LSW_COORD_W-1:0];
                  if (cstep[`LSW_COORD_W])
                    state_nxt.row = rstep[`LSW_COORD_W-1:0];
                end
              end
            end
          endcase
        end
      end
    end
  end

  // Window resets to the full screen
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r <= '0;
      state_r.col_end <= lsw_coord_t'(H_PIXELS - 1);
      state_r.row_end <= lsw_coord_t'(V_PIXELS - 1);
      state_r.word <= `LSW_WORD_RST;
    end
    else
      state_r <= state_nxt;
  end

  assign word_valid = state_r.word_valid;
  assign word = state_r.word;
  assign word_is_cmd = state_r.word_is_cmd;
  assign frame_memory_we = state_r.fm_we;
  assign frame_memory_addr = state_r.fm_addr;
  assign frame_memory_pixel = state_r.fm_pixel;
  assign backlight_on = state_r.backlight;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  property p_desel_clear;
    @(posedge clock) disable iff (!rst_n) cs_n_s |=> state_r.bit_cnt == 3'h0 && !state_r.word_valid;
  endproperty
  a_desel_clear: assert property (p_desel_clear) else $error("bit counter not cleared on deselect");

  property p_idle_hold;
    @(posedge clock) disable iff (!rst_n) cs_n_s |=> $stable(state_r.shift);
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("shift moved while deselected");

  property p_one_bit;
    @(posedge clock) disable iff (!rst_n)
      !cs_n_s && sclk_rise |=> state_r.bit_cnt == $past(state_r.bit_cnt) + 3'h1 && state_r.shift[0] == $past(sdi_s);
  endproperty
  a_one_bit: assert property (p_one_bit) else $error("edge did not take exactly one bit");

  property p_word_done;
    @(posedge clock) disable iff (!rst_n)
      !cs_n_s && sclk_rise && state_r.bit_cnt == 3'h7 |=> word_valid ##1 !word_valid;
  endproperty
  a_word_done: assert property (p_word_done) else $error("eighth bit gave no single word pulse");

  property p_msb_first;
    @(posedge clock) disable iff (!rst_n) $rose(word_valid) |-> word[7:1] == $past(state_r.shift[6:0]);
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("earlier bits not in top positions");

  property p_classify;
    @(posedge clock) disable iff (!rst_n)
      !cs_n_s && sclk_rise && state_r.bit_cnt == 3'h7 |=> word_is_cmd == !$past(cmd_data_level);
  endproperty
  a_classify: assert property (p_classify) else $error("word class does not follow select level");

  property p_backlight;
    @(posedge clock) disable iff (!rst_n) ##1 backlight_on == $past(bl_s);
  endproperty
  a_backlight: assert property (p_backlight) else $error("backlight does not follow control");

  property p_pixel;
    @(posedge clock) disable iff (!rst_n)
      frame_memory_we |-> !word_is_cmd && frame_memory_pixel.blue == word[7:2]
                         && frame_memory_addr < `LSW_ADDR_W'(H_PIXELS * V_PIXELS);
  endproperty
  a_pixel: assert property (p_pixel) else $error("pixel write malformed or out of range");

  property p_step;
    @(posedge clock) disable iff (!rst_n)
      frame_memory_we && !scan_mode.row_first && !scan_mode.col_dec && $past(state_r.col) != state_r.col_end
      |-> state_r.col == $past(state_r.col) + lsw_coord_t'(1);
  endproperty
  a_step: assert property (p_step) else $error("column did not advance after pixel");

endmodule : lsw_write_port

`default_nettype wire

//--- logic/lsw_params.svh
`ifndef LSW_PARAMS_SVH
`define LSW_PARAMS_SVH

// ****************************************************************
// Serial framing
// ****************************************************************
`define LSW_LAST_BIT 3'h7
`define LSW_BIT_CNT_RST 3'h0
`define LSW_WORD_RST 8'h00

// ****************************************************************
// Geometry and frame memory
// ****************************************************************
`define LSW_H_PIXELS 320
`define LSW_V_PIXELS 480
`define LSW_FRAME_BYTES 345600
`define LSW_PIXEL_BITS 18
`define LSW_COLOR_W 6
`define LSW_COORD_W 9
`define LSW_ADDR_W 18

// ****************************************************************
// Address window and memory write commands, synchroniser depth
// ****************************************************************
`define LSW_CMD_COL_SET 8'h2A
`define LSW_CMD_ROW_SET 8'h2B
`define LSW_CMD_MEM_WRITE 8'h2C
`define LSW_ARG_LAST 2'h3
`define LSW_PIX_LAST 2'h2
`define LSW_SYNC_STAGES 2

`endif

//--- logic/lsw_pkg.sv
`default_nettype none
`include "lsw_params.svh"

package lsw_pkg;

  // Scan direction selection
  typedef struct packed {
    logic row_dec;
    logic col_dec;
    logic row_first;
  } lsw_scan_s;

  // One pixel, six bits per colour
  typedef struct packed {
    logic [`LSW_COLOR_W-1:0] red;
    logic [`LSW_COLOR_W-1:0] green;
    logic [`LSW_COLOR_W-1:0] blue;
  } lsw_pixel_s;

  typedef enum logic [1:0] {MODE_IDLE, MODE_COL, MODE_ROW, MODE_WRITE} lsw_mode_e;

  typedef logic [`LSW_COORD_W-1:0] lsw_coord_t;

  // Whole state of the write port
  typedef struct packed {
    logic sclk_prev;
    logic [7:0] shift;
    logic [2:0] bit_cnt;
    logic [7:0] word;
    logic word_valid;
    logic word_is_cmd;
    lsw_mode_e mode;
    logic [1:0] arg_idx;
    logic [7:0] arg_hi;
    lsw_coord_t col_start;
    lsw_coord_t col_end;
    lsw_coord_t row_start;
    lsw_coord_t row_end;
    lsw_coord_t col;
    lsw_coord_t row;
    logic [`LSW_COLOR_W-1:0] red;
    logic [`LSW_COLOR_W-1:0] green;
    logic fm_we;
    logic [`LSW_ADDR_W-1:0] fm_addr;
    lsw_pixel_s fm_pixel;
    logic backlight;
  } lsw_state_s;

endpackage : lsw_pkg

`default_nettype wire

//--- logic/lsw_sync.sv
`default_nettype none
`include "lsw_params.svh"

module lsw_sync
  import lsw_pkg::*;
#(
  parameter int W = 4
)
(
  input wire logic clock, // System clock
  input wire logic rst_n, // Async reset
  input wire logic [W-1:0] d, // Asynchronous pin levels
  output logic [W-1:0] q // Synchronised levels
);

  logic [`LSW_SYNC_STAGES-1:0][W-1:0] sync_r;
  logic [`LSW_SYNC_STAGES-1:0][W-1:0] sync_nxt;

  initial
  begin
    if (W < 1) $error("lsw_sync: width must be at least one");
  end

  // Only the second stage is seen outside, against metastability
  always_comb
  begin
    sync_nxt = {sync_r[0], d};
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      sync_r <= '0;
    else
      sync_r <= sync_nxt;
  end

  assign q = sync_r[1];

endmodule : lsw_sync

`default_nettype wire

//--- verif/lsw_host_model.sv
`default_nettype none

// ****************************************************************
// Serial master standing in for the host controller
// ****************************************************************
module lsw_host_model
(
  input wire logic clock, // Bench clock, pins move on its falling edge
  output logic chip_select_n, // Select, active low
  output logic command_data_select, // Low command, high data
  output logic serial_clock, // Link clock, 800 ns period
  output logic serial_data // Data, MSB first
);
  timeunit 1ns;
  timeprecision 1ns;

  logic last_bit;

  // Idle: deselected, link clock low
  initial
  begin
    chip_select_n = 1'b1;
    command_data_select = 1'b0;
    serial_clock = 1'b0;
    serial_data = 1'b1;
    last_bit = 1'b0;
  end

  // Half a link period is four bench clocks
  task automatic half();
    repeat (4) @(negedge clock);
  endtask : half

  // Shift nbits of b out, top bit first, select held low throughout
  task automatic send(input logic dc, input logic [7:0] b, input int nbits);
    int i;
    @(negedge clock);
    chip_select_n = 1'b0;
    command_data_select = dc;
    for (i = 7; i > 7 - nbits; i--)
    begin
      serial_data = b[i];
      last_bit = b[i];
      half();
      serial_clock = 1'b1; // bit set up a half period before the rise
      half();
      serial_clock = 1'b0;
    end
  endtask : send

  // Release select; the released data line shows no stale level
  task automatic deselect();
    @(negedge clock);
    chip_select_n = 1'b1;
    serial_data = ~last_bit;
    repeat (8) @(negedge clock);
  endtask : deselect

  // Clock pulses while deselected, a fault the block must ignore
  task automatic stray(input int n);
    int i;
    for (i = 0; i < n; i++)
    begin
      half();
      serial_clock = 1'b1;
      serial_data = ~serial_data;
      half();
      serial_clock = 1'b0;
    end
  endtask : stray

endmodule : lsw_host_model

`default_nettype wire

//--- verif/lsw_write_port_tb.sv
`default_nettype none

module lsw_write_port_tb
  import lsw_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic clock, rst_n, chip_select_n, command_data_select, serial_clock, serial_data;
  logic backlight_enable, word_valid, word_is_cmd, frame_memory_we, backlight_on;
  lsw_scan_s scan_mode;
  logic [7:0] word;
  logic [17:0] frame_memory_addr;
  lsw_pixel_s frame_memory_pixel;
  int num_errors = 0;
  int n_compared = 0;
  int seed = 94;
  logic [8:0] exp_w[$];
  logic [35:0] exp_p[$];
  logic [8:0] ew;
  logic [35:0] ep;
  logic [31:0] v;
  logic [15:0] rs;
  int i, m, k;

  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  lsw_host_model u_host (.clock(clock), .chip_select_n(chip_select_n),
    .command_data_select(command_data_select), .serial_clock(serial_clock), .serial_data(serial_data));

  lsw_write_port u_dut (.clock(clock), .rst_n(rst_n), .chip_select_n(chip_select_n),
    .command_data_select(command_data_select), .serial_clock(serial_clock), .serial_data(serial_data),
    .backlight_enable(backlight_enable), .scan_mode(scan_mode), .word_valid(word_valid), .word(word),
    .word_is_cmd(word_is_cmd), .frame_memory_we(frame_memory_we), .frame_memory_addr(frame_memory_addr),
    .frame_memory_pixel(frame_memory_pixel), .backlight_on(backlight_on));

  // ****************************************************************
  // Compare tasks and verdict
  // ****************************************************************
  task automatic chk_word(input logic [8:0] got, input logic [8:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_word

  task automatic chk_pix(input logic [35:0] got, input logic [35:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_pix

  task automatic chk_bit(input logic got, input logic exp);
    n_compared++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_bit

  task automatic final_report();
    $display("counts: %0d compared, %0d mismatches", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report

  // Expected pixel index in a 2x2 window at cols 318..319, rows r0..r0+1
  function automatic logic [17:0] exp_addr(input lsw_scan_s sm, input int r0, input int n);
    int ci, ri, col, row;
    ci = sm.row_first ? n / 2 : n % 2;
    ri = sm.row_first ? n % 2 : n / 2;
    col = sm.col_dec ? 319 - ci : 318 + ci;
    row = sm.row_dec ? r0 + 1 - ri : r0 + ri;
    return 18'(row * 320 + col);
  endfunction : exp_addr

  // Queue the expected word, then send it whole
  task automatic put(input logic dc, input logic [7:0] b);
    exp_w.push_back({~dc, b});
    u_host.send(dc, b, 8);
  endtask : put

  // ****************************************************************
  // Monitors: every word and pixel write must be expected, in order
  // ****************************************************************
  // Falling edge: registered pulses have settled mid-cycle; an unexpected
  // output meets a floating expectation so even unknowns count as bad
  always @(negedge clock)
  begin
    if (word_valid === 1'b1)
    begin
      ew = (exp_w.size() != 0) ? exp_w.pop_front() : 9'bZ_ZZZZ_ZZZZ;
      chk_word({word_is_cmd, word}, ew);
    end
    if (frame_memory_we === 1'b1)
    begin
      ep = (exp_p.size() != 0) ? exp_p.pop_front() : {36{1'bZ}};
      chk_pix({frame_memory_addr, frame_memory_pixel}, ep);
    end
  end

  // Watchdog, far beyond the under two thousand link bits sent
  initial
  begin
    #5000000;
    num_errors++;
    $display("watchdog expired");
    final_report();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    rst_n = 1'b0;
    backlight_enable = 1'b0;
    scan_mode = '0;
    repeat (12) @(posedge clock);
    @(negedge clock);
    rst_n = 1'b1;
    repeat (3) @(negedge clock);
    // Random words; commands kept off the window and write codes
    put(1'b1, 8'h00);
    put(1'b1, 8'hFF);
    for (i = 0; i < 24; i++)
    begin
      v = $random(seed);
      put(v[8], {v[7] | ~v[8], v[6:0]});
    end
    $display("test words done");
    // Partial word lost on deselect, stray clocks ignored
    u_host.send(1'b0, 8'hA5, 5);
    u_host.deselect();
    u_host.stray(3);
    put(1'b1, 8'h3C);
    repeat (8) @(negedge clock);
    chk_bit(exp_w.size() == 0, 1'b1);
    $display("test abort done");
    // One 2x2 frame per scan mode at the right-hand edge
    for (m = 0; m < 8; m++)
    begin
      scan_mode = lsw_scan_s'(m[2:0]);
      v = $random(seed);
      rs = 16'((v & 32'h1FF) % 479);
      put(1'b0, 8'h2A);
      put(1'b1, 8'h01);
      put(1'b1, 8'h3E);
      put(1'b1, 8'h01);
      put(1'b1, 8'h3F);
      put(1'b0, 8'h2B);
      put(1'b1, rs[15:8]);
      put(1'b1, rs[7:0]);
      put(1'b1, 8'(16'(rs + 16'h1) >> 8));
      put(1'b1, 8'(rs + 16'h1));
      put(1'b0, 8'h2C);
      for (k = 0; k < 4; k++)
      begin
        v = $random(seed);
        exp_p.push_back({exp_addr(scan_mode, int'(rs), k), v[17:0]});
        put(1'b1, {v[17:12], v[1:0]});
        put(1'b1, {v[11:6], v[21:20]});
        put(1'b1, {v[5:0], v[19:18]});
      end
    end
    $display("test frames done");
    // Backlight follows its control input
    for (i = 0; i < 6; i++)
    begin
      v = $random(seed);
      @(negedge clock);
      backlight_enable = v[0];
      repeat (4) @(negedge clock);
      chk_bit(backlight_on, v[0]);
    end
    $display("test backlight done");
    // Mid-run reset restores the full-screen window at its corner
    scan_mode = '0;
    @(negedge clock);
    rst_n = 1'b0;
    repeat (2) @(negedge clock);
    rst_n = 1'b1;
    repeat (3) @(negedge clock);
    put(1'b0, 8'h2C);
    v = $random(seed);
    exp_p.push_back({18'h00000, v[17:0]});
    put(1'b1, {v[17:12], 2'h0});
    put(1'b1, {v[11:6], 2'h3});
    put(1'b1, {v[5:0], 2'h1});
    $display("test reset done");
    repeat (8) @(negedge clock);
    chk_bit(exp_w.size() == 0 && exp_p.size() == 0, 1'b1);
    final_report();
  end

endmodule : lsw_write_port_tb

`default_nettype wire
